// ==== hdl/uep_regs.svh ====
/*
 * register map constants for the uart event and publish register block.
 * assumes inclusion by bare name from the package and the test bench.
 */
// How it works
// - rx timeout flag at 0x144, zero until a receiver timeout or a software write of one sets it
// - rx started flag at 0x14c, set once the receiver begins operating
// - tx started flag at 0x150, set once the transmitter begins operating
// - tx stopped flag at 0x158, set when the transmitter has halted
// - 0x180 holds channel and enable; clear-to-send published only when enabled
// - 0x184 selects channel and enable for clear-to-send-deasserted publishing
// - 0x188 configures channel and enable for byte-received publishing
// - 0x190 configures channel and enable for rx-buffer-end publishing
// - 0x19c configures channel and enable for byte-sent publishing
// - 0x1a0 configures channel and enable for tx-end publishing
// - 0x1a4 configures channel and enable for error publishing
// - software may enable or disable the rx timeout interrupt individually
`ifndef UEP_REGS_SVH
`define UEP_REGS_SVH

// ---------------------------------------------------------------------
// offsets
// ---------------------------------------------------------------------
`define UEP_OFF_RX_TIMEOUT  12'h144
`define UEP_OFF_RX_STARTED  12'h14c
`define UEP_OFF_TX_STARTED  12'h150
`define UEP_OFF_TX_STOPPED  12'h158
`define UEP_OFF_PUB_CTS     12'h180
`define UEP_OFF_PUB_CLEAR_TO_SEND_DEASSERTED    12'h184
`define UEP_OFF_PUB_BRX     12'h188
`define UEP_OFF_PUB_RXEND   12'h190
`define UEP_OFF_PUB_BTX     12'h19c
`define UEP_OFF_PUB_TXEND   12'h1a0
`define UEP_OFF_PUB_ERR     12'h1a4
`define UEP_OFF_INT_STATUS  12'h308
`define UEP_OFF_INT_MASK    12'h30c

// ---------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------
`define UEP_CH_MSB          7
`define UEP_EN_BIT          31
`define UEP_RESET_VAL       32'h0000_0000
`define UEP_NUM_PUB         7
`define UEP_NUM_FLAG        4
`define UEP_RESP_OKAY       2'h0
`define UEP_RESP_SLVERR     2'h2

`endif

// ==== hdl/uep_pkg.sv ====
/*
 * types for the uart event and publish register block.
 * assumes uep_regs.svh is on the include path.
 */
`default_nettype none
package uep_pkg;
`include "uep_regs.svh"

    // publish sources, in register order
    typedef enum logic [2:0] {
        UEP_PUB_CTS, UEP_PUB_CLEAR_TO_SEND_DEASSERTED, UEP_PUB_BRX, UEP_PUB_RXEND,
        UEP_PUB_BTX, UEP_PUB_TXEND, UEP_PUB_ERR
    } uep_pub_e;

    // sticky flag positions: timeout, rx started, tx started, tx stopped
    typedef logic [`UEP_NUM_FLAG-1:0] uep_flags_t;

    // write channel progress
    typedef enum logic [1:0] {
        UEP_W_IDLE, UEP_W_RESP
    } uep_wst_e;

    // whole module state
    typedef struct packed {
        uep_flags_t             flags;
        uep_flags_t             mask;
        logic [`UEP_NUM_PUB-1:0] pub_en;
        logic [`UEP_NUM_PUB-1:0][7:0] pub_ch;
        logic                   aw_held;
        logic [11:0]            aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        uep_wst_e               wst;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [`UEP_NUM_PUB-1:0] pub_pulse;
        logic [`UEP_NUM_PUB-1:0][7:0] pub_chan;
    } uep_state_s;
endpackage
`default_nettype wire

// ==== hdl/uep_event_regs.sv ====
/*
 * event flags, publish configuration and interrupt for a dma uart.
 * assumes event pulses arrive one cycle wide on aclk from the uart engine,
 * and a single axi4-lite master on the same clock.
 */
`default_nettype none
module uep_event_regs
    import uep_pkg::*;
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               rx_timeout,
    input  wire logic               rx_started,
    input  wire logic               tx_started,
    input  wire logic               tx_stopped,
    input  wire logic [6:0]         pub_event,
    output logic [6:0]              pub_valid,
    output logic [6:0][7:0]         pub_channel,
    output logic                    irq
);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------

    // map an offset to a publish slot, 7 when none
    function automatic logic [2:0] pub_slot(input logic [11:0] a);
        case (a)
            `UEP_OFF_PUB_CTS:   pub_slot = 3'h0;
            `UEP_OFF_PUB_CLEAR_TO_SEND_DEASSERTED:  pub_slot = 3'h1;
            `UEP_OFF_PUB_BRX:   pub_slot = 3'h2;
            `UEP_OFF_PUB_RXEND: pub_slot = 3'h3;
            `UEP_OFF_PUB_BTX:   pub_slot = 3'h4;
            `UEP_OFF_PUB_TXEND: pub_slot = 3'h5;
            `UEP_OFF_PUB_ERR:   pub_slot = 3'h6;
            default:            pub_slot = 3'h7;
        endcase
    endfunction

    // map an offset to an event flag slot, 4 when none
    function automatic logic [2:0] flag_slot(input logic [11:0] a);
        case (a)
            `UEP_OFF_RX_TIMEOUT: flag_slot = 3'h0;
            `UEP_OFF_RX_STARTED: flag_slot = 3'h1;
            `UEP_OFF_TX_STARTED: flag_slot = 3'h2;
            `UEP_OFF_TX_STOPPED: flag_slot = 3'h3;
            default:             flag_slot = 3'h4;
        endcase
    endfunction

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    uep_state_s st_r;
    uep_state_s st_nxt;
    uep_flags_t ev_in;
    logic       wr_go;

    assign ev_in = {tx_stopped, tx_started, rx_started, rx_timeout};
    assign wr_go = st_r.aw_held && st_r.w_held && (st_r.wst == UEP_W_IDLE);

    // handshake outputs
    assign s_axi_awready = !st_r.aw_held && (st_r.wst == UEP_W_IDLE);
    assign s_axi_wready  = !st_r.w_held && (st_r.wst == UEP_W_IDLE);
    assign s_axi_bvalid  = (st_r.wst == UEP_W_RESP);
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;
    assign pub_valid     = st_r.pub_pulse;
    assign pub_channel   = st_r.pub_chan;
    assign irq           = |(st_r.flags & st_r.mask);

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        logic [2:0]  ps;
        logic [2:0]  fs;
        logic [31:0] wd;
        uep_flags_t  clr;
        st_nxt = st_r;
        ps     = 3'h7;
        fs     = 3'h4;
        wd     = st_r.w_data;
        clr    = '0;

        // address and data capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_held = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end

        // register write
        case (st_r.wst)
            UEP_W_IDLE: begin
                if (wr_go) begin
                    ps = pub_slot(st_r.aw_addr);
                    fs = flag_slot(st_r.aw_addr);
                    st_nxt.aw_held = 1'b0;
                    st_nxt.w_held  = 1'b0;
                    st_nxt.wst     = UEP_W_RESP;
                    st_nxt.bresp   = `UEP_RESP_OKAY;
                    if (ps != 3'h7) begin
                        if (st_r.w_strb[0]) begin
                            st_nxt.pub_ch[ps] = wd[`UEP_CH_MSB:0];
                        end
                        if (st_r.w_strb[3]) begin
                            st_nxt.pub_en[ps] = wd[`UEP_EN_BIT];
                        end
                    end else if (fs != 3'h4) begin
                        // writing zero clears a flag, one sets it
                        if (st_r.w_strb[0]) begin
                            st_nxt.flags[fs[1:0]] = wd[0];
                            clr[fs[1:0]] = !wd[0];
                        end
                    end else if (st_r.aw_addr == `UEP_OFF_INT_STATUS) begin
                        if (st_r.w_strb[0]) begin
                            clr = wd[`UEP_NUM_FLAG-1:0];
                            st_nxt.flags = st_r.flags & ~clr;
                        end
                    end else if (st_r.aw_addr == `UEP_OFF_INT_MASK) begin
                        if (st_r.w_strb[0]) begin
                            st_nxt.mask = wd[`UEP_NUM_FLAG-1:0];
                        end
                    end else begin
                        st_nxt.bresp = `UEP_RESP_SLVERR;
                    end
                end
            end
            UEP_W_RESP: begin
                if (s_axi_bready) begin
                    st_nxt.wst = UEP_W_IDLE;
                end
            end
            default: st_nxt.wst = UEP_W_IDLE;
        endcase

        // hardware events win over a clear in the same cycle
        st_nxt.flags = st_nxt.flags | ev_in;

        // register read
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = `UEP_RESP_OKAY;
            st_nxt.rdata  = `UEP_RESET_VAL;
            ps = pub_slot(s_axi_araddr);
            fs = flag_slot(s_axi_araddr);
            if (ps != 3'h7) begin
                st_nxt.rdata = {st_r.pub_en[ps], 23'h0, st_r.pub_ch[ps]};
            end else if (fs != 3'h4) begin
                st_nxt.rdata = {31'h0, st_r.flags[fs[1:0]]};
            end else if (s_axi_araddr == `UEP_OFF_INT_STATUS) begin
                st_nxt.rdata = {28'h0, st_r.flags};
            end else if (s_axi_araddr == `UEP_OFF_INT_MASK) begin
                st_nxt.rdata = {28'h0, st_r.mask};
            end else begin
                st_nxt.rresp = `UEP_RESP_SLVERR;
            end
        end

        // forward enabled events to their channel
        for (int i = 0; i < `UEP_NUM_PUB; i++) begin
            st_nxt.pub_pulse[i] = pub_event[i] && st_r.pub_en[i];
            st_nxt.pub_chan[i]  = st_r.pub_ch[i];
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_timeout_ev;
        rx_timeout;
    endsequence

    a_rx_timeout_flag_set: assert property (s_timeout_ev |=> st_r.flags[0])
        else $error("timeout flag not set");
    a_rxst_flag_set: assert property (rx_started |=> st_r.flags[1])
        else $error("rx started flag not set");
    a_txst_flag_set: assert property (tx_started |=> st_r.flags[2])
        else $error("tx started flag not set");
    a_txsp_flag_set: assert property (tx_stopped |=> st_r.flags[3])
        else $error("tx stopped flag not set");
    a_cts_pub_gate: assert property (
        pub_event[0] |=> pub_valid[0] == $past(st_r.pub_en[0]))
        else $error("cts publish gate wrong");
    a_clear_to_send_deasserted_pub_off: assert property (
        !st_r.pub_en[1] |=> !pub_valid[1])
        else $error("clear_to_send_deasserted published while disabled");
    a_brx_pub_chan: assert property (
        pub_valid[2] |-> pub_channel[2] == $past(st_r.pub_ch[2]))
        else $error("byte received channel wrong");
    a_rxend_pub_gate: assert property (
        pub_valid[3] |-> $past(pub_event[3]) && $past(st_r.pub_en[3]))
        else $error("rx end pulse without cause");
    a_btx_pub_gate: assert property (
        pub_valid[4] |-> $past(pub_event[4]) && $past(st_r.pub_en[4]))
        else $error("byte sent pulse without cause");
    a_txend_pub_gate: assert property (
        pub_valid[5] |-> $past(pub_event[5]) && $past(st_r.pub_en[5]))
        else $error("tx end pulse without cause");
    a_err_pub_gate: assert property (
        pub_event[6] && st_r.pub_en[6] |=> pub_valid[6] ##1 1'b1)
        else $error("error not published");
    a_irq_mask_gate: assert property (
        !st_r.mask[0] && st_r.flags[3:1] == 3'h0 |-> !irq)
        else $error("masked timeout raised irq");
    a_reset_zero_state: assert property (
        $rose(aresetn) |-> st_r.pub_en == '0 && st_r.flags == '0)
        else $error("state not zero after reset");

    // -----------------------------------------------------------------
    // bus, field and sticky flag checks
    // -----------------------------------------------------------------

    // read address taken this cycle
    sequence s_ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // address and data both held, register updated this cycle
    sequence s_wr_commit;
        wr_go;
    endsequence

    // read answered on the next cycle
    a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
        else $error("read not answered");

    // write answered on the cycle after the update
    a_write_answer: assert property (s_wr_commit |=> s_axi_bvalid)
        else $error("write not answered");

    // unmapped reads return zero
    a_unmapped_zero: assert property (
        s_axi_rvalid && s_axi_rresp == `UEP_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("unmapped read not zero");

    // bits between channel and enable read zero
    a_read_pad_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[30:8] == 23'h0)
        else $error("reserved bits not zero");

    // publish register writes answer okay
    a_pub_write_okay: assert property (
        s_wr_commit ##0 pub_slot(st_r.aw_addr) != 3'h7 |=> s_axi_bresp == `UEP_RESP_OKAY)
        else $error("publish write refused");

    // channel field follows a low-lane write
    a_cts_chan_write: assert property (
        s_wr_commit ##0 (pub_slot(st_r.aw_addr) == 3'h0 && st_r.w_strb[0])
        |=> st_r.pub_ch[0] == $past(st_r.w_data[7:0]))
        else $error("cts channel not written");

    // enable field follows a top-lane write
    a_err_en_write: assert property (
        s_wr_commit ##0 (pub_slot(st_r.aw_addr) == 3'h6 && st_r.w_strb[3])
        |=> st_r.pub_en[6] == $past(st_r.w_data[31]))
        else $error("error enable not written");

    // enable bits kept when the top lane is not written
    a_en_lane_keep: assert property (
        s_wr_commit ##0 !st_r.w_strb[3] |=> st_r.pub_en == $past(st_r.pub_en))
        else $error("enable changed without its lane");

    // timeout flag stays set until software writes
    a_rx_timeout_sticky: assert property (
        st_r.flags[0] && !wr_go |=> st_r.flags[0])
        else $error("timeout flag lost");

    // rx started flag stays set until software writes
    a_rxst_sticky: assert property (
        st_r.flags[1] && !wr_go |=> st_r.flags[1])
        else $error("rx started flag lost");

    // tx started flag stays set until software writes
    a_txst_sticky: assert property (
        st_r.flags[2] && !wr_go |=> st_r.flags[2])
        else $error("tx started flag lost");

    // tx stopped flag stays set until software writes
    a_txsp_sticky: assert property (
        st_r.flags[3] && !wr_go |=> st_r.flags[3])
        else $error("tx stopped flag lost");

    // timeout flag rises only on its event or a write
    a_rx_timeout_no_spur: assert property (
        !st_r.flags[0] && !rx_timeout && !wr_go |=> !st_r.flags[0])
        else $error("timeout flag set without cause");

    // tx stopped flag rises only on its event or a write
    a_txsp_no_spur: assert property (
        !st_r.flags[3] && !tx_stopped && !wr_go |=> !st_r.flags[3])
        else $error("tx stopped flag set without cause");

    // clear-to-send pulse carries its configured channel
    a_cts_pub_chan: assert property (
        pub_valid[0] |-> pub_channel[0] == $past(st_r.pub_ch[0]))
        else $error("cts channel wrong");

    // deasserted pulse only from an enabled event
    a_clear_to_send_deasserted_pub_gate: assert property (
        pub_valid[1] |-> $past(pub_event[1]) && $past(st_r.pub_en[1]))
        else $error("clear_to_send_deasserted pulse without cause");

    // byte received pulse only from an enabled event
    a_brx_pub_gate: assert property (
        pub_valid[2] |-> $past(pub_event[2]) && $past(st_r.pub_en[2]))
        else $error("byte received pulse without cause");

    // error stays quiet while disabled
    a_err_pub_off: assert property (
        !st_r.pub_en[6] |=> !pub_valid[6])
        else $error("error published while disabled");

    // unmasked timeout raises the interrupt
    a_irq_rx_timeout: assert property (
        st_r.flags[0] && st_r.mask[0] |-> irq)
        else $error("unmasked timeout without irq");

endmodule
`default_nettype wire

// ==== test/uep_event_src.sv ====
/*
 * model of the uart engine that feeds event pulses into the register block.
 * assumes the bench drives the trigger inputs one cycle wide on aclk.
 */
`default_nettype none
module uep_event_src (
    input  wire logic        aclk,
    input  wire logic        slow,
    input  wire logic [3:0]  trig_flag,
    input  wire logic [6:0]  trig_pub,
    output logic [3:0]       flag_pulse,
    output logic [6:0]       pub_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] stage;

    // -----------------------------------------------------------------
    // pulse generation
    // -----------------------------------------------------------------
    // one-cycle pulses, one or two cycles after the trigger
    initial begin
        stage = '0;
        flag_pulse = '0;
        pub_pulse = '0;
    end
    always @(posedge aclk) begin
        stage <= {trig_pub, trig_flag};
        {pub_pulse, flag_pulse} <= slow ? stage : {trig_pub, trig_flag};
    end
endmodule
`default_nettype wire

// ==== test/uart_event_publish_regs_test.sv ====
/*
 * self-checking bench for the event and publish register block.
 * assumes uep_regs.svh on the include path and uep_event_src beside it.
 */
`default_nettype none
`include "uep_regs.svh"
module uart_event_publish_regs_test
    import uep_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, slow = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 4'hf, trig_flag = 0, flag_pulse;
    logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1; // answers always taken
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic [6:0] trig_pub = 0, pub_event, pub_valid;
    logic [6:0][7:0] pub_channel;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    logic [11:0] offs [11] = '{`UEP_OFF_RX_TIMEOUT, `UEP_OFF_RX_STARTED,
        `UEP_OFF_TX_STARTED, `UEP_OFF_TX_STOPPED, `UEP_OFF_PUB_CTS,
        `UEP_OFF_PUB_CLEAR_TO_SEND_DEASSERTED, `UEP_OFF_PUB_BRX, `UEP_OFF_PUB_RXEND,
        `UEP_OFF_PUB_BTX, `UEP_OFF_PUB_TXEND, `UEP_OFF_PUB_ERR};

    uep_event_regs uep_event_regs_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rx_timeout(flag_pulse[0]), .rx_started(flag_pulse[1]),
        .tx_started(flag_pulse[2]), .tx_stopped(flag_pulse[3]),
        .pub_event(pub_event), .pub_valid(pub_valid),
        .pub_channel(pub_channel), .irq(irq));
    uep_event_src uep_event_src_inst (.aclk(aclk), .slow(slow),
        .trig_flag(trig_flag), .trig_pub(trig_pub),
        .flag_pulse(flag_pulse), .pub_pulse(pub_event));

    // -----------------------------------------------------------------
    // clock, watchdog, reporting
    // -----------------------------------------------------------------
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // ends a hung run
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // -----------------------------------------------------------------
    // bus tasks; entered just after a rising edge, ready sampled on it
    // -----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic tb;
        tb = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (!tb) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid === 1'b1) begin
                tb = 1;
                r = bresp;
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        logic tr;
        tr = 0;
        araddr <= a;
        arvalid <= 1;
        while (!tr) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid === 1'b1) begin
                tr = 1;
                d = rdata;
                r = rresp;
            end
        end
    endtask
    // one-cycle trigger to the engine model
    task automatic fire(input logic [3:0] f, input logic [6:0] p);
        trig_flag <= f;
        trig_pub <= p;
        @(posedge aclk);
        trig_flag <= 0;
        trig_pub <= 0;
        repeat (3) @(posedge aclk);
    endtask

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    // reset values, field masking, unmapped access
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 11; i++) begin
            rd(offs[i], d, r);
            chk(d, 32'h0, "reset value");
            chk(32'(r), 32'h0, "read resp");
        end
        for (int i = 4; i < 11; i++) begin
            wr(offs[i], 32'hffff_ffff, r);
            chk(32'(r), 32'h0, "write resp");
            rd(offs[i], d, r);
            chk(d, 32'h8000_00ff, "pub fields");
            wr(offs[i], 32'h0, r);
        end
        // byte lanes: low lane holds the channel, top lane the enable
        wstrb <= 4'h1;
        wr(offs[4], 32'h8000_00a5, r);
        rd(offs[4], d, r);
        chk(d, 32'h0000_00a5, "low lane only");
        wstrb <= 4'h8;
        wr(offs[4], 32'h8000_005a, r);
        rd(offs[4], d, r);
        chk(d, 32'h8000_00a5, "top lane only");
        wstrb <= 4'hf;
        wr(offs[4], 32'h0, r);
        rd(12'h000, d, r);
        chk(32'(r), 32'h2, "unmapped read resp");
        chk(d, 32'h0, "unmapped read data");
        wr(12'h004, 32'h1, r);
        chk(32'(r), 32'h2, "unmapped write resp");
        $display("test reset done");
    endtask
    // each flag sets on its event and clears on a zero write
    task automatic t_flags();
        logic [31:0] d;
        logic [1:0] r;
        for (int f = 0; f < 4; f++) begin
            fire(4'(1 << f), 7'h0);
            rd(offs[f], d, r);
            chk(d, 32'h1, "flag set");
            rd(`UEP_OFF_INT_STATUS, d, r);
            chk(d, 32'(1 << f), "status");
            wr(offs[f], 32'h0, r);
            rd(offs[f], d, r);
            chk(d, 32'h0, "flag clear");
        end
        $display("test flags done");
    endtask
    // each slot published only when enabled, on its channel
    task automatic t_pub();
        logic [31:0] d, v, xv;
        logic [1:0] r;
        logic [7:0] ch;
        logic prev;
        for (int i = 0; i < 7; i++) begin
            for (int e = 0; e < 2; e++) begin
                slow <= i[0];
                ch = 8'(8'h11 * i + 3);
                v = {e[0], 23'h0, ch};
                wr(offs[4 + i], v, r);
                rd(offs[4 + i], d, r);
                chk(d, v, "pub cfg");
                trig_pub <= 7'(1 << i);
                prev = 0;
                // each edge shows what the edge before launched
                repeat (5) begin
                    @(posedge aclk);
                    trig_pub <= 0;
                    xv = (prev && e) ? 32'(1 << i) : 32'h0;
                    chk(32'(pub_valid), xv, "pub");
                    if (prev && e) chk(32'(pub_channel[i]), 32'(ch), "chan");
                    prev = pub_event[i];
                end
                @(posedge aclk);
            end
        end
        $display("test publish done");
    endtask
    // rx timeout interrupt enabled by the mask, tx stopped interrupt masked then unmasked
    task automatic t_irq();
        logic [1:0] r;
        wr(`UEP_OFF_INT_MASK, 32'h1, r);
        fire(4'h8, 7'h0);
        chk(32'(irq), 32'h0, "masked irq");
        fire(4'h1, 7'h0);
        chk(32'(irq), 32'h1, "irq");
        wr(`UEP_OFF_INT_STATUS, 32'h1, r);
        chk(32'(irq), 32'h0, "irq cleared");
        wr(`UEP_OFF_INT_MASK, 32'h9, r);
        chk(32'(irq), 32'h1, "irq unmasked");
        wr(`UEP_OFF_INT_STATUS, 32'h8, r);
        chk(32'(irq), 32'h0, "irq off");
        $display("test irq done");
    endtask

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        t_reset();
        t_flags();
        t_pub();
        t_irq();
        finish_test();
    end
endmodule
`default_nettype wire
